// file: pkg/cmc_pkg.sv
// constants, types and timing counts for the transceiver mode control block
// How it works
// - mode select high or open gives Standby
// - normal mode, transmit high: drivers off
// - normal mode, transmit low: drivers on, dominant
// - dominant protection variant times out stuck transmit
// - standby ignores transmit, never drives bus
// - normal mode drives receive output both ways
// - standby before wake: receive output weakly high
// - after wake, receive output driven and toggling
// - standby drivers off, wake variant pulls down
// - unpowered leaves bus terminals fully passive
// - standby reports nothing except the wake report
// - wake logic runs on io supply alone
// - wake needs dominant, recessive, dominant within timeout
// - timeout shutdown recovers on transmit high
// - overtemperature recovery needs cool plus falling transmit
// - core undervoltage forces Standby, io undervoltage unpowers
package cmc_pkg;

	// ***********************************************************
	// clock and timing
	// ***********************************************************
	localparam int CLK_PERIOD_NS    = 10;                 // mclk period
	localparam int DOM_TIMEOUT_US   = 1000;               // dominant_timeout_time
	localparam int DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int WAKE_FILTER_NS   = 500;                // least level time per wake event
	localparam int WAKE_FILTER_CYC  = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_TIMEOUT_US  = 1000;               // longest time for all three events
	localparam int WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

	// ***********************************************************
	// reset values
	// ***********************************************************
	localparam logic SYNC_RST_LEVEL = 1'h1;               // pins idle high (pull-ups)
	localparam logic RX_RST_LEVEL   = 1'h1;               // receive output idles high

	// ***********************************************************
	// types
	// ***********************************************************
	typedef enum logic [1:0] {
		CMC_NORMAL    = 2'b00,
		CMC_STANDBY   = 2'b01,
		CMC_UNPOWERED = 2'b10
	} cmc_mode_t;

	typedef enum logic [2:0] {
		CMC_WK_IDLE = 3'b000,
		CMC_WK_DOM1 = 3'b001,
		CMC_WK_REC2 = 3'b010,
		CMC_WK_DOM3 = 3'b011,
		CMC_WK_SEEN = 3'b100
	} cmc_wake_t;

	typedef struct packed {
		logic level;                                      // level to present on receive output
		logic drive;                                      // push-pull active for this word
	} cmc_rx_word_t;

endpackage

// file: rtl/cmc_mode_control.sv
// transceiver mode control: mode select, driver control, wake-up and receive path
`timescale 1ns/1ns
module cmc_mode_control
	import cmc_pkg::*;
#(
	parameter bit DOM_PROTECT  = 1'b1,                   // variant with dominant protection
	parameter bit WAKE_SUPPORT = 1'b1,                   // variant with bus wake-up
	parameter int DOM_LIMIT    = DOM_TIMEOUT_CYC,        // dominant timeout in cycles
	parameter int WAKE_LIMIT   = WAKE_TIMEOUT_CYC,       // wake window in cycles
	parameter int FILT_LIMIT   = WAKE_FILTER_CYC         // wake event filter in cycles
)(
	input  wire logic mclk,                              // 100 MHz clock
	input  wire logic rst,                               // synchronous reset, high
	input  wire logic modeSelect,                        // high or open selects Standby
	input  wire logic txDataIn,                          // transmit data, low = dominant
	input  wire logic busDominant,                       // bus receiver, high = dominant
	input  wire logic overTemp,                          // above thermal_shutdown_level
	input  wire logic tempWarm,                          // above shutdown level minus hysteresis
	input  wire logic coreSupplyLow,                     // core supply undervoltage
	input  wire logic ioSupplyLow,                       // io_supply undervoltage
	input  wire logic rxReady,                           // receiver may take a word
	output logic      canHighDrive,                      // high-side driver on
	output logic      canLowDrive,                       // low-side driver on
	output logic      busBiasOn,                         // recessive bias active
	output logic      busPullDown,                       // weak pull to ground via bus_input_resistance
	output logic      rxDataOut,                         // receive data level
	output logic      rxDataOe                           // receive push-pull enabled
);

	// ***********************************************************
	// input synchronisers and mode
	// ***********************************************************
	logic      modeSync1;                                // first stage, read by modeSync2 only
	logic      modeSync2;                                // synchronised mode select
	logic      txSync1;                                  // first stage, read by txSync2 only
	logic      txSync2;                                  // synchronised transmit data
	logic      txPrev;                                   // previous transmit level
	cmc_mode_t modeReg;                                  // current operating mode
	cmc_mode_t next_mode;                                // decoded next mode

	// both pins settle high when open, so reset to the idle level
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			modeSync1 <= SYNC_RST_LEVEL;
			modeSync2 <= SYNC_RST_LEVEL;
			txSync1   <= SYNC_RST_LEVEL;
			txSync2   <= SYNC_RST_LEVEL;
			txPrev    <= SYNC_RST_LEVEL;
		end
		else
		begin
			modeSync1 <= modeSelect;
			modeSync2 <= modeSync1;
			txSync1   <= txDataIn;
			txSync2   <= txSync1;
			txPrev    <= txSync2;
		end
	end

	// io loss beats core loss beats the pin
	assign next_mode = ioSupplyLow ? CMC_UNPOWERED :
	                   (coreSupplyLow || modeSync2) ? CMC_STANDBY :
	                   CMC_NORMAL;

	// mode register
	always_ff @(posedge mclk)
	begin
		if (rst)
			modeReg <= CMC_STANDBY;
		else
			modeReg <= next_mode;
	end

	wire isNormal  = (modeReg == CMC_NORMAL);            // normal mode decode
	wire isStandby = (modeReg == CMC_STANDBY);           // standby mode decode
	wire txFall    = txPrev && !txSync2;                 // transmit high-to-low edge

	// ***********************************************************
	// dominant timeout and overtemperature latch
	// ***********************************************************
	logic [$clog2(DOM_LIMIT+1)-1:0] domCnt;              // cycles transmit held low
	logic                           domTimedOut;         // drivers shut by timeout
	logic                           otLatch;             // drivers shut by overtemperature

	wire domHit = DOM_PROTECT && !txSync2 && (domCnt == ($bits(domCnt))'(DOM_LIMIT));

	// counter only runs while a dominant is being sent; a high clears it
	always_ff @(posedge mclk)
	begin
		if (rst || txSync2 || !isNormal)
			domCnt <= '0;
		else if (!domHit)
			domCnt <= domCnt + 1'b1;
	end

	// timeout latch: set on limit, cleared as soon as transmit returns high
	always_ff @(posedge mclk)
	begin
		if (rst)
			domTimedOut <= 1'b0;
		else if (domHit)
			domTimedOut <= 1'b1;
		else if (txSync2)
			domTimedOut <= 1'b0;
	end

	// overtemperature: a set in the same cycle as a recovery wins
	always_ff @(posedge mclk)
	begin
		if (rst)
			otLatch <= 1'b0;
		else if (overTemp)
			otLatch <= 1'b1;
		else if (!tempWarm && txFall)
			otLatch <= 1'b0;
	end

	// faults override transmit; standby and unpowered never drive
	wire driveOn = isNormal && !txSync2 && !domTimedOut && !otLatch;

	// ***********************************************************
	// wake-up detector, kept alive on the io supply alone
	// ***********************************************************
	cmc_wake_t                       wakeState;          // wake sequence state
	cmc_wake_t                       next_wake;          // next wake state
	logic [$clog2(FILT_LIMIT+1)-1:0] filtCnt;            // cycles in current level
	logic [$clog2(WAKE_LIMIT+1)-1:0] windowCnt;          // cycles since first dominant

	wire filtDone   = (filtCnt == ($bits(filtCnt))'(FILT_LIMIT));
	wire windowOut  = (windowCnt == ($bits(windowCnt))'(WAKE_LIMIT));
	wire wakeActive = WAKE_SUPPORT && isStandby;
	wire wakeSeen   = (wakeState == CMC_WK_SEEN);

	// the window guards against a stuck dominant raising a false wake
	always_comb
	begin
		next_wake = wakeState;
		case (wakeState)
			CMC_WK_IDLE: if (busDominant) next_wake = CMC_WK_DOM1;
			CMC_WK_DOM1: if (!busDominant) next_wake = filtDone ? CMC_WK_REC2 : CMC_WK_IDLE;
			CMC_WK_REC2: if (busDominant) next_wake = filtDone ? CMC_WK_DOM3 : CMC_WK_IDLE;
			CMC_WK_DOM3: if (filtDone) next_wake = CMC_WK_SEEN;
			             else if (!busDominant) next_wake = CMC_WK_IDLE;
			CMC_WK_SEEN: next_wake = CMC_WK_SEEN;
			default:     next_wake = CMC_WK_IDLE;
		endcase
		if (windowOut && wakeState != CMC_WK_SEEN)
			next_wake = CMC_WK_IDLE;
	end

	// wake state, filter and window counters
	always_ff @(posedge mclk)
	begin
		if (rst || !wakeActive)
		begin
			wakeState <= CMC_WK_IDLE;
			filtCnt   <= '0;
			windowCnt <= '0;
		end
		else
		begin
			wakeState <= next_wake;
			filtCnt   <= (next_wake != wakeState) ? '0 : (filtDone ? filtCnt : filtCnt + 1'b1);
			windowCnt <= (next_wake == CMC_WK_IDLE || windowOut) ? '0 : windowCnt + 1'b1;
		end
	end

	// ***********************************************************
	// receive path through a two-entry buffer
	// ***********************************************************
	cmc_rx_word_t bufMem [2];                            // buffer entries
	logic         wrIdx;                                 // write index
	logic         rdIdx;                                 // read index
	logic [1:0]   bufCount;                              // words held
	cmc_rx_word_t inWord;                                // word offered to the buffer

	// standby shows nothing but the wake report, held high until then
	assign inWord.drive = isNormal || (wakeActive && wakeSeen);
	assign inWord.level = inWord.drive ? !busDominant : RX_RST_LEVEL;

	wire bufInReady = (bufCount != 2'h2);                // stalls bus sampling when full
	wire bufOutVal  = (bufCount != 2'h0);
	wire push       = bufInReady;                        // a sample is offered every cycle
	wire pop        = bufOutVal && rxReady;

	// a stalled receiver holds the output; a word popped while the present mode forbids driving is dropped
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrIdx    <= 1'b0;
			rdIdx    <= 1'b0;
			bufCount <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				bufMem[wrIdx] <= inWord;
				wrIdx         <= ~wrIdx;
			end
			if (pop)
				rdIdx <= ~rdIdx;
			bufCount <= bufCount + {1'b0, push} - {1'b0, pop};
		end
	end

	// ***********************************************************
	// output registers
	// ***********************************************************
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			canHighDrive <= 1'b0;
			canLowDrive  <= 1'b0;
			busBiasOn    <= 1'b0;
			busPullDown  <= 1'b0;
			rxDataOut    <= RX_RST_LEVEL;
			rxDataOe     <= 1'b0;
		end
		else
		begin
			canHighDrive <= driveOn;
			canLowDrive  <= driveOn;
			busBiasOn    <= isNormal;
			busPullDown  <= isStandby && WAKE_SUPPORT;
			// a word buffered before a mode change must not drive the pin
			// once the present mode forbids it, so release at once
			if (!inWord.drive)
			begin
				rxDataOut <= RX_RST_LEVEL;
				rxDataOe  <= 1'b0;
			end
			else if (pop)
			begin
				rxDataOut <= bufMem[rdIdx].level;
				rxDataOe  <= bufMem[rdIdx].drive;
			end
		end
	end

	// ***********************************************************
	// assertions
	// ***********************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence seqWakeDom3;
		wakeState == CMC_WK_DOM3 && busDominant && filtDone && !windowOut;
	endsequence

	AST_MODE_STANDBY: assert property (modeSync2 && !ioSupplyLow |=> modeReg == CMC_STANDBY)
		else $error("mode select high did not give standby");
	AST_CORE_UV: assert property (coreSupplyLow && !ioSupplyLow |=> modeReg == CMC_STANDBY)
		else $error("core undervoltage did not force standby");
	AST_RECESSIVE: assert property (isNormal && txSync2 |=> !canHighDrive && !canLowDrive)
		else $error("drivers on while transmit high");
	AST_DOMINANT: assert property (isNormal && !txSync2 && !domTimedOut && !otLatch
		|=> canHighDrive && canLowDrive)
		else $error("drivers off while sending dominant");
	AST_DOM_TIMEOUT: assert property (domHit |=> domTimedOut ##1 !canLowDrive)
		else $error("dominant timeout did not release bus");
	AST_TX_RECOVER: assert property (domTimedOut && txSync2 |=> !domTimedOut)
		else $error("timeout not cleared by transmit high");
	AST_STANDBY_QUIET: assert property (!isNormal |=> !canHighDrive && !canLowDrive)
		else $error("bus driven outside normal mode");
	AST_PULLDOWN: assert property (isStandby |=> busPullDown == WAKE_SUPPORT && !busBiasOn)
		else $error("standby bus termination wrong");
	AST_UNPOWERED: assert property (modeReg == CMC_UNPOWERED |=> !busPullDown && !busBiasOn)
		else $error("bus terminals biased while unpowered");
	AST_WAKE_SEQ: assert property ($rose(wakeSeen) |-> $past(wakeState) == CMC_WK_DOM3)
		else $error("wake reported without full sequence");
	AST_WAKE_REACH: assert property (wakeActive and seqWakeDom3 |=> wakeSeen)
		else $error("full wake sequence not reported");
	AST_OT_HOLD: assert property (otLatch && (tempWarm || !txFall) |=> otLatch)
		else $error("overtemperature released too early");
	AST_RX_WEAK: assert property (isStandby && !wakeSeen |=> !rxDataOe)
		else $error("receive output driven before wake");

endmodule

// file: sim/cmc_ctrl_model.sv
// protocol controller model: drives the mode and transmit pins, consumes receive words
`timescale 1ns/1ns
module cmc_ctrl_model
	import cmc_pkg::*;
(
	input  wire logic mclk,       // system clock
	input  wire logic stbWant,    // requested mode pin level
	input  wire logic txWant,     // requested transmit level
	input  wire logic stallWant,  // request to stall the receive side
	input  wire logic rxDataOut,  // receive level from the device
	input  wire logic rxDataOe,   // receive push-pull enable
	output logic      modeSelect, // mode pin, high selects standby
	output logic      txDataIn,   // transmit pin, low is dominant
	output logic      rxReady,    // receive word accepted this cycle
	output logic      rxWire      // level seen on the receive wire
);
	// ***********************************************************
	// pin drive
	// ***********************************************************
	logic stbHold;                // request taken at the edge
	logic txHold;                 // request taken at the edge
	logic stallHold;              // request taken at the edge

	// pins idle high like the pull-ups, so the device starts in standby;
	// one process owns every pin: requests taken at the edge, shown just after it
	initial
	begin
		modeSelect = 1'b1;
		txDataIn = 1'b1;
		rxReady = 1'b1;
		forever
		begin
			@(posedge mclk);
			stbHold = stbWant;
			txHold = txWant;
			stallHold = stallWant;
			#1;
			modeSelect = stbHold;
			txDataIn = txHold;
			rxReady = !stallHold;
		end
	end

	// a released receive line reads high through the weak pull-up
	assign rxWire = rxDataOe ? rxDataOut : 1'b1;
endmodule

// file: sim/cmc_mode_control_bench.sv
// self-checking bench for the transceiver mode control block
`timescale 1ns/1ns
`define CMC_CHK(nm, ex, got) \
	begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("mismatch %s expected %b seen %b", nm, ex, got); end end
module cmc_mode_control_bench
	import cmc_pkg::*;
;
	// ***********************************************************
	// signals and instances
	// ***********************************************************
	localparam int DOM_L = 50;    // shortened dominant timeout
	logic mclk, rst, stbW, txW, stallW, busDominant, overTemp, tempWarm;
	logic coreSupplyLow, ioSupplyLow, modeSelect, txDataIn, rxReady, rxWire;
	logic canHighDrive, canLowDrive, busBiasOn, busPullDown, rxDataOut, rxDataOe;
	logic bareLow, barePull, bareOe; // outputs of the variant without protection or wake
	logic [31:0] rb;              // random bits
	int   n_mismatch, compares, mBlock, mWoke, k;

	cmc_mode_control #(.DOM_LIMIT(DOM_L), .WAKE_LIMIT(200), .FILT_LIMIT(4)) dut (
		.mclk(mclk), .rst(rst), .modeSelect(modeSelect), .txDataIn(txDataIn),
		.busDominant(busDominant), .overTemp(overTemp), .tempWarm(tempWarm),
		.coreSupplyLow(coreSupplyLow), .ioSupplyLow(ioSupplyLow), .rxReady(rxReady),
		.canHighDrive(canHighDrive), .canLowDrive(canLowDrive), .busBiasOn(busBiasOn),
		.busPullDown(busPullDown), .rxDataOut(rxDataOut), .rxDataOe(rxDataOe));
	// variant without dominant protection and without wake-up, fed the same pins
	cmc_mode_control #(.DOM_PROTECT(1'b0), .WAKE_SUPPORT(1'b0), .DOM_LIMIT(DOM_L),
		.WAKE_LIMIT(200), .FILT_LIMIT(4)) dutBare (
		.mclk(mclk), .rst(rst), .modeSelect(modeSelect), .txDataIn(txDataIn),
		.busDominant(busDominant), .overTemp(overTemp), .tempWarm(tempWarm),
		.coreSupplyLow(coreSupplyLow), .ioSupplyLow(ioSupplyLow), .rxReady(rxReady),
		.canHighDrive(), .canLowDrive(bareLow), .busBiasOn(),
		.busPullDown(barePull), .rxDataOut(), .rxDataOe(bareOe));
	cmc_ctrl_model ctrl (.mclk(mclk), .stbWant(stbW), .txWant(txW), .stallWant(stallW),
		.rxDataOut(rxDataOut), .rxDataOe(rxDataOe), .modeSelect(modeSelect),
		.txDataIn(txDataIn), .rxReady(rxReady), .rxWire(rxWire));

	// ***********************************************************
	// tasks and model
	// ***********************************************************
	// every input change lands 1 ns after an edge
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task setp(input logic stb, tx, bus, core, io, input int n);
		stbW = stb;
		txW = tx;
		busDominant = bus;
		coreSupplyLow = core;
		ioSupplyLow = io;
		step(n);
	endtask

	// reference model: mode from pins and supplies, then every output
	task check_model;
		int md;
		logic drv, oe;
		md = ioSupplyLow ? 2 : ((stbW || coreSupplyLow) ? 1 : 0);
		drv = (md == 0) && !txW && (mBlock == 0);
		oe = (md == 0) || (md == 1 && mWoke != 0);
		`CMC_CHK("canHighDrive", drv, canHighDrive)
		`CMC_CHK("canLowDrive", drv, canLowDrive)
		`CMC_CHK("busBiasOn", md == 0, busBiasOn)
		`CMC_CHK("busPullDown", md == 1, busPullDown)
		`CMC_CHK("rxDataOe", oe, rxDataOe)
		`CMC_CHK("rxWire", oe ? !busDominant : 1'b1, rxWire)
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ***********************************************************
	// clock, watchdog and sequence
	// ***********************************************************
	initial
	begin
		mclk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
	end

	// a hang counts as a mismatch and still reaches the verdict
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		$display("mismatch watchdog expected end seen hang");
		finish_test;
	end

	initial
	begin
		{rst, stbW, txW} = 3'h7;
		{stallW, busDominant, overTemp, tempWarm, coreSupplyLow, ioSupplyLow} = 6'h00;
		n_mismatch = 0;
		compares = 0;
		mBlock = 0;
		mWoke = 0;
		rb = $urandom(25);
		step(6);
		rst = 1'b0;
		step(3);
		check_model;
		$display("test reset done");
		// random traffic, transmit kept high every other step so no timeout builds up
		for (int i = 0; i < 12; i++)
		begin
			rb = $urandom;
			setp(1'b0, (i % 2 == 1) ? rb[0] : 1'b1, rb[1], 1'b0, 1'b0, 6);
			check_model;
		end
		setp(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8);
		check_model;
		$display("test normal and standby done");
		setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10);
		check_model;
		step(DOM_L);
		mBlock = 1;
		check_model;
		`CMC_CHK("bareLow", 1'b1, bareLow)
		setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 6);
		mBlock = 0;
		setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6);
		check_model;
		$display("test dominant timeout done");
		// overtemperature: a falling edge while still warm must not release; cooling plus a falling edge does
		{overTemp, tempWarm} = 2'h3;
		mBlock = 1;
		step(4);
		check_model;
		overTemp = 1'b0;
		setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 6);
		setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6);
		check_model;
		tempWarm = 1'b0;
		setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 6);
		setp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 6);
		mBlock = 0;
		check_model;
		$display("test overtemperature done");
		setp(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8);
		check_model;
		setp(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8);
		check_model;
		$display("test undervoltage done");
		// wake on core-low standby: short pulse, then a sequence that outlives the window
		setp(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2);
		setp(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 10);
		setp(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 6);
		setp(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 250);
		// the third dominant arrives after the window ran out: no report
		setp(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 10);
		check_model;
		setp(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 250);
		setp(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 6);
		setp(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 6);
		busDominant = 1'b1;
		k = 0;
		while (rxDataOe !== 1'b1 && k < 20)
		begin
			step(1);
			k++;
		end
		`CMC_CHK("wakeDelay", 1'b1, k >= 4 && k < 20)
		mWoke = 1;
		step(3);
		check_model;
		`CMC_CHK("bareOe", 1'b0, bareOe)
		`CMC_CHK("barePull", 1'b0, barePull)
		setp(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4);
		check_model;
		setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8);
		mWoke = 0;
		setp(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8);
		check_model;
		$display("test wake done");
		// receiver stall: the held word stays, then the newer level comes through
		setp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8);
		stallW = 1'b1;
		setp(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8);
		`CMC_CHK("rxWire", 1'b1, rxWire)
		stallW = 1'b0;
		step(6);
		check_model;
		$display("test receive stall done");
		finish_test;
	end
endmodule
